// [rtl/bmf_pkg.sv]
package bmf_pkg;

    // Register indices. Byte address on APB is four times the index.
    localparam logic [7:0] IDX_CELL_LOW   = 8'h54;
    localparam logic [7:0] IDX_CELL_HIGH  = 8'h56;
    localparam logic [7:0] IDX_AUX        = 8'h58;
    localparam logic [7:0] IDX_CMP_LOW    = 8'h5A;
    localparam logic [7:0] IDX_CMP_HIGH   = 8'h5C;
    localparam logic [7:0] IDX_LINK       = 8'h5E;
    localparam logic [7:0] IDX_CONFIG     = 8'h60;
    localparam logic [7:0] IDX_CELL_THR   = 8'h61;
    localparam logic [7:0] IDX_SUMMARY    = 8'h62;
    localparam logic [7:0] IDX_AUX_THR0   = 8'h64;

    localparam int NUM_CELLS    = 16;
    localparam int NUM_AUX      = 8;
    localparam int NUM_SYS      = 4;
    localparam int RESULT_W     = 16;

    // Field positions.
    localparam int AUX_LOW_LSB  = 8;
    localparam int AUX_HIGH_LSB = 0;
    localparam int LINK_LSB     = 12;
    localparam int LINK_W       = 4;
    localparam int LINK_UP_MIS  = 3;
    localparam int LINK_LO_MIS  = 2;
    localparam int LINK_UP_ABT  = 1;
    localparam int LINK_LO_ABT  = 0;
    localparam int CFG_SELF_CLR = 0;
    localparam int THR_HIGH_LSB = 16;
    localparam int SUM_LSB      = 9;
    localparam int SUM_W        = 7;

    // Mismatches in one frame that stop its reception.
    localparam logic [1:0] ABORT_COUNT = 2'h2;

    // Values after reset.
    localparam logic [15:0] FLAGS_RST    = 16'h0000;
    localparam logic [15:0] LOW_THR_RST  = 16'h0000;
    localparam logic [15:0] HIGH_THR_RST = 16'hFFFF;

    typedef struct packed {
        logic bit_valid;
        logic rx_bit;
        logic rx_bit_inv;
        logic frame_start;
        logic frame_end;
    } bmf_link_rx_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } bmf_apb_req_t;

    typedef enum logic [2:0] {
        LNK_IDLE = 3'b001,
        LNK_RECV = 3'b010,
        LNK_STOP = 3'b100
    } bmf_link_state_t;

endpackage : bmf_pkg

// [rtl/bmf_flag_bank.sv]
`timescale 1ns/10ps
module bmf_flag_bank
    import bmf_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set_cond,
    input  wire logic [W-1:0] clear_mask,
    input  wire logic         auto_clear,
    output logic      [W-1:0] flags_q
);

    logic [W-1:0] flags_d;

    // A setting condition in the same cycle as a clear leaves the flag set.
    always_comb begin
        flags_d = set_cond | (flags_q & ~clear_mask & {W{~auto_clear}});
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= FLAGS_RST[W-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule : bmf_flag_bank

// [rtl/bmf_link_check.sv]
`timescale 1ns/10ps
module bmf_link_check
    import bmf_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire bmf_link_rx_t rx,
    output logic              mismatch_q,
    output logic              abort_q,
    output logic              stop_q
);

    bmf_link_state_t state_q;
    logic [1:0]      count_q;
    logic            mismatch;

    // Each received bit travels with its complement; equal values are an error.
    assign mismatch = rx.bit_valid & (rx.rx_bit == rx.rx_bit_inv);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LNK_IDLE;
            count_q <= 2'h0;
        end else begin
            case (state_q)
                LNK_IDLE: begin
                    if (rx.frame_start) begin
                        state_q <= LNK_RECV;
                        count_q <= 2'h0;
                    end
                end
                LNK_RECV: begin
                    if (rx.frame_start) begin
                        count_q <= 2'h0;
                    end else if (rx.frame_end) begin
                        state_q <= LNK_IDLE;
                    end else if (mismatch) begin
                        count_q <= count_q + 2'h1;
                        if (count_q + 2'h1 >= ABORT_COUNT) begin
                            state_q <= LNK_STOP;
                        end
                    end
                end
                LNK_STOP: begin
                    if (rx.frame_start) begin
                        state_q <= LNK_RECV;
                        count_q <= 2'h0;
                    end else if (rx.frame_end) begin
                        state_q <= LNK_IDLE;
                    end
                end
                default: begin
                    state_q <= LNK_IDLE;
                    count_q <= 2'h0;
                end
            endcase
        end
    end

    // A single mismatch only notifies; the frame keeps being received.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mismatch_q <= 1'b0;
            abort_q    <= 1'b0;
        end else begin
            mismatch_q <= mismatch & (state_q == LNK_RECV) & ~rx.frame_start;
            abort_q    <= mismatch & (state_q == LNK_RECV) & ~rx.frame_start
                          & ~rx.frame_end & (count_q + 2'h1 >= ABORT_COUNT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
        end else if (rx.frame_start || rx.frame_end) begin
            stop_q <= 1'b0;
        end else if (abort_q) begin
            stop_q <= 1'b1;
        end
    end

endmodule : bmf_link_check

// [rtl/bmf_fault_flags.sv]
`timescale 1ns/10ps
module bmf_fault_flags
    import bmf_pkg::*;
#(
    parameter int RW = RESULT_W
) (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [11:0]                       paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata_q,
    output logic                                   pready_q,
    output logic                                   pslverr_q,
    input  wire logic [NUM_CELLS-1:0][RW-1:0]      cell_result,
    input  wire logic [NUM_AUX-1:0][RW-1:0]        aux_result,
    input  wire logic [NUM_CELLS-1:0]              comparator_low_in,
    input  wire logic [NUM_CELLS-1:0]              comparator_high_in,
    input  wire logic [NUM_SYS-1:0]                system_fault_flags,
    input  wire bmf_link_rx_t                      upper_link_port,
    input  wire bmf_link_rx_t                      lower_link_port,
    output logic                                   upper_link_stop_q,
    output logic                                   lower_link_stop_q,
    output logic      [SUM_W-1:0]                  fault_category_summary_q
);

    bmf_apb_req_t req;
    logic         access_done;
    logic         wr_done;
    logic [15:0]  wr_mask;
    logic [15:0]  link_clear;

    logic                 self_clearing_flags_option_q;
    logic [RW-1:0]        cell_low_threshold_q;
    logic [RW-1:0]        cell_high_threshold_q;
    logic [NUM_AUX-1:0][RW-1:0] aux_low_threshold_q;
    logic [NUM_AUX-1:0][RW-1:0] aux_high_threshold_q;

    logic [NUM_CELLS-1:0] cell_low_cond;
    logic [NUM_CELLS-1:0] cell_high_cond;
    logic [NUM_AUX-1:0]   aux_low_cond;
    logic [NUM_AUX-1:0]   aux_high_cond;
    logic                 analog_die_active;

    logic [NUM_CELLS-1:0] cell_low_flags;
    logic [NUM_CELLS-1:0] cell_high_flags;
    logic [15:0]          aux_flags;
    logic [NUM_CELLS-1:0] comparator_low_flags;
    logic [NUM_CELLS-1:0] comparator_high_flags;
    logic [LINK_W-1:0]    link_flags;
    logic [LINK_W-1:0]    link_events;

    logic up_mis;
    logic up_abort;
    logic lo_mis;
    logic lo_abort;

    logic [31:0] rd_data;
    logic        rd_hit;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Word index of a byte address; low two bits are ignored.
    function automatic logic [7:0] word_index(input logic [11:0] addr);
        return addr[9:2];
    endfunction : word_index

    // Clear mask for one flag register. The bus values travel as arguments, because a
    // port expression that calls a function only wakes up when its arguments change.
    function automatic logic [15:0] clear_for(input logic [7:0]  idx,
                                              input logic [11:0] addr,
                                              input logic [15:0] mask);
        return (word_index(addr) == idx) ? mask : 16'h0000;
    endfunction : clear_for

    // No wait state: the read word is captured in the setup cycle, so
    // pready rises with penable and every access takes exactly two cycles.
    assign access_done = req.psel & req.penable & pready_q;
    assign wr_done     = access_done & req.pwrite;
    assign wr_mask     = wr_done ? req.pwdata[15:0] : 16'h0000;
    assign link_clear  = clear_for(IDX_LINK, req.paddr, wr_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (req.psel && !req.penable) begin
            pready_q  <= 1'b1;
            pslverr_q <= ~rd_hit;
            prdata_q  <= req.pwrite ? 32'h0000_0000 : rd_data;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_clearing_flags_option_q <= 1'b0;
            cell_low_threshold_q         <= LOW_THR_RST[RW-1:0];
            cell_high_threshold_q        <= HIGH_THR_RST[RW-1:0];
        end else if (wr_done) begin
            if (word_index(req.paddr) == IDX_CONFIG) begin
                self_clearing_flags_option_q <= req.pwdata[CFG_SELF_CLR];
            end
            if (word_index(req.paddr) == IDX_CELL_THR) begin
                cell_low_threshold_q  <= req.pwdata[RW-1:0];
                cell_high_threshold_q <= req.pwdata[THR_HIGH_LSB +: RW];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux_thr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    aux_low_threshold_q[gi]  <= LOW_THR_RST[RW-1:0];
                    aux_high_threshold_q[gi] <= HIGH_THR_RST[RW-1:0];
                end else if (wr_done && word_index(req.paddr) == IDX_AUX_THR0 + 8'(gi)) begin
                    aux_low_threshold_q[gi]  <= req.pwdata[RW-1:0];
                    aux_high_threshold_q[gi] <= req.pwdata[THR_HIGH_LSB +: RW];
                end
            end
            assign aux_low_cond[gi]  = aux_result[gi] < aux_low_threshold_q[gi];
            assign aux_high_cond[gi] = aux_result[gi] > aux_high_threshold_q[gi];
        end
        for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell_cmp
            assign cell_low_cond[gi]  = cell_result[gi] < cell_low_threshold_q;
            assign cell_high_cond[gi] = cell_result[gi] > cell_high_threshold_q;
        end
    endgenerate

    // Raw inputs are used here, so a fault that software has masked
    // elsewhere still holds the comparator flags.
    assign analog_die_active = (|system_fault_flags) | (|comparator_low_in)
                               | (|comparator_high_in);

    bmf_flag_bank #(.W(NUM_CELLS)) u_cell_low (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   (cell_low_cond),
        .clear_mask (clear_for(IDX_CELL_LOW, req.paddr, wr_mask)),
        .auto_clear (self_clearing_flags_option_q),
        .flags_q    (cell_low_flags)
    );

    bmf_flag_bank #(.W(NUM_CELLS)) u_cell_high (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   (cell_high_cond),
        .clear_mask (clear_for(IDX_CELL_HIGH, req.paddr, wr_mask)),
        .auto_clear (self_clearing_flags_option_q),
        .flags_q    (cell_high_flags)
    );

    bmf_flag_bank #(.W(16)) u_aux (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   ({aux_low_cond, aux_high_cond}),
        .clear_mask (clear_for(IDX_AUX, req.paddr, wr_mask)),
        .auto_clear (self_clearing_flags_option_q),
        .flags_q    (aux_flags)
    );

    bmf_flag_bank #(.W(NUM_CELLS)) u_cmp_low (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   (comparator_low_in),
        .clear_mask (clear_for(IDX_CMP_LOW, req.paddr, wr_mask)),
        .auto_clear (self_clearing_flags_option_q & ~analog_die_active),
        .flags_q    (comparator_low_flags)
    );

    bmf_flag_bank #(.W(NUM_CELLS)) u_cmp_high (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   (comparator_high_in),
        .clear_mask (clear_for(IDX_CMP_HIGH, req.paddr, wr_mask)),
        .auto_clear (self_clearing_flags_option_q & ~analog_die_active),
        .flags_q    (comparator_high_flags)
    );

    bmf_link_check u_upper (
        .pclk       (pclk),
        .presetn    (presetn),
        .rx         (upper_link_port),
        .mismatch_q (up_mis),
        .abort_q    (up_abort),
        .stop_q     (upper_link_stop_q)
    );

    bmf_link_check u_lower (
        .pclk       (pclk),
        .presetn    (presetn),
        .rx         (lower_link_port),
        .mismatch_q (lo_mis),
        .abort_q    (lo_abort),
        .stop_q     (lower_link_stop_q)
    );

    always_comb begin
        link_events              = '0;
        link_events[LINK_UP_MIS] = up_mis;
        link_events[LINK_LO_MIS] = lo_mis;
        link_events[LINK_UP_ABT] = up_abort;
        link_events[LINK_LO_ABT] = lo_abort;
    end

    // Link errors are events, not conditions, so they always latch.
    bmf_flag_bank #(.W(LINK_W)) u_link (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_cond   (link_events),
        .clear_mask (link_clear[LINK_LSB +: LINK_W]),
        .auto_clear (1'b0),
        .flags_q    (link_flags)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_category_summary_q <= '0;
        end else begin
            fault_category_summary_q <= {|cell_low_flags, |cell_high_flags,
                                         |aux_flags[AUX_LOW_LSB +: NUM_AUX],
                                         |aux_flags[AUX_HIGH_LSB +: NUM_AUX],
                                         |comparator_low_flags, |comparator_high_flags,
                                         |link_flags};
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (word_index(req.paddr))
            IDX_CELL_LOW:  rd_data[15:0] = cell_low_flags;
            IDX_CELL_HIGH: rd_data[15:0] = cell_high_flags;
            IDX_AUX:       rd_data[15:0] = aux_flags;
            IDX_CMP_LOW:   rd_data[15:0] = comparator_low_flags;
            IDX_CMP_HIGH:  rd_data[15:0] = comparator_high_flags;
            IDX_LINK:      rd_data[LINK_LSB +: LINK_W] = link_flags;
            IDX_CONFIG:    rd_data[CFG_SELF_CLR] = self_clearing_flags_option_q;
            IDX_CELL_THR:  rd_data = {cell_high_threshold_q, cell_low_threshold_q};
            IDX_SUMMARY:   rd_data[SUM_LSB +: SUM_W] = fault_category_summary_q;
            default: begin
                if (word_index(req.paddr) >= IDX_AUX_THR0
                    && word_index(req.paddr) < IDX_AUX_THR0 + 8'(NUM_AUX)) begin
                    rd_data = {aux_high_threshold_q[3'(word_index(req.paddr) - IDX_AUX_THR0)],
                               aux_low_threshold_q[3'(word_index(req.paddr) - IDX_AUX_THR0)]};
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

endmodule : bmf_fault_flags

// [sim/bmf_fault_flags_monitor.sv]
`timescale 1ns/10ps
module bmf_fault_flags_monitor
    import bmf_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [11:0]          paddr,
    input wire logic                 pready_q,
    input wire logic                 pslverr_q,
    input wire logic [NUM_CELLS-1:0] comparator_low_in,
    input wire logic [NUM_CELLS-1:0] comparator_high_in,
    input wire bmf_link_rx_t         upper_link_port,
    input wire bmf_link_rx_t         lower_link_port,
    input wire logic                 upper_link_stop_q,
    input wire logic                 lower_link_stop_q,
    input wire logic [SUM_W-1:0]     fault_category_summary_q
);
    default clocking mcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic up_mis;
    logic lo_mis;
    logic up_edge;
    assign up_mis = upper_link_port.bit_valid
                    && upper_link_port.rx_bit == upper_link_port.rx_bit_inv;
    assign lo_mis = lower_link_port.bit_valid
                    && lower_link_port.rx_bit == lower_link_port.rx_bit_inv;
    assign up_edge = upper_link_port.frame_start || upper_link_port.frame_end;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready_q ##1 !pready_q;
    endsequence
    apb_answer_a: assert property (setup_s |=> answer_s)
        else $error("ready did not follow setup");
    ready_access_a: assert property (pready_q |-> psel && penable)
        else $error("ready outside access");
    error_ready_a: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    mapped_ok_a: assert property (pready_q && paddr == 12'h150 |-> !pslverr_q)
        else $error("error on mapped flag register");
    cmp_low_sum_a: assert property (|comparator_low_in |-> ##2 fault_category_summary_q[2])
        else $error("comparator low summary missing");
    cmp_high_sum_a: assert property (|comparator_high_in |-> ##2 fault_category_summary_q[1])
        else $error("comparator high summary missing");
    up_stop_a: assert property ($rose(upper_link_stop_q) |-> $past(up_mis, 2))
        else $error("upper stop without mismatch");
    lo_stop_a: assert property ($rose(lower_link_stop_q) |-> $past(lo_mis, 2))
        else $error("lower stop without mismatch");
    up_hold_a: assert property ($fell(upper_link_stop_q) |-> $past(up_edge) || $past(up_edge, 2))
        else $error("upper stop dropped inside frame");
endmodule : bmf_fault_flags_monitor

bind bmf_fault_flags bmf_fault_flags_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .comparator_low_in(comparator_low_in), .comparator_high_in(comparator_high_in),
    .upper_link_port(upper_link_port), .lower_link_port(lower_link_port),
    .upper_link_stop_q(upper_link_stop_q), .lower_link_stop_q(lower_link_stop_q),
    .fault_category_summary_q(fault_category_summary_q));

// [sim/bmf_link_model.sv]
`timescale 1ns/10ps
module bmf_link_model
    import bmf_pkg::*;
(
    input  wire logic   pclk,
    output bmf_link_rx_t port
);
    logic busy = 1'b0;
    initial port = '0;
    // Between frames both data lines toggle together, so a compare not gated by valid shows up.
    always @(posedge pclk) begin
        if (!busy) begin
            port <= '{1'b0, ~port.rx_bit, ~port.rx_bit, 1'b0, 1'b0};
        end
    end
    task automatic frame(input int n, input logic [7:0] bad, input logic fin);
        busy = 1'b1;
        @(posedge pclk);
        port <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            port <= '{1'b1, i[0], bad[i] ? i[0] : ~i[0], 1'b0, 1'b0};
        end
        @(posedge pclk);
        port <= '{1'b0, 1'b0, 1'b1, 1'b0, fin};
        busy <= 1'b0;
    endtask : frame
endmodule : bmf_link_model

// [sim/battery_monitor_fault_flags_test.sv]
`timescale 1ns/10ps
module battery_monitor_fault_flags_test
    import bmf_pkg::*;
();
    logic                             pclk, presetn, psel, penable, pwrite;
    logic [11:0]                      paddr;
    logic [31:0]                      pwdata, prdata_q, r;
    logic                             pready_q, pslverr_q, up_stop, lo_stop, e;
    logic [NUM_CELLS-1:0][RESULT_W-1:0] cell_res;
    logic [NUM_AUX-1:0][RESULT_W-1:0] aux_res;
    logic [NUM_CELLS-1:0]             cmp_lo, cmp_hi;
    logic [NUM_SYS-1:0]               sys_f;
    logic [SUM_W-1:0]                 sum_q;
    bmf_link_rx_t                     up_port, lo_port;
    int                               n_errors = 0;
    int                               checks = 0;
    localparam logic [11:0] RA [10] = '{12'h150, 12'h158, 12'h160, 12'h168, 12'h170,
                                        12'h178, 12'h180, 12'h184, 12'h188, 12'h190};

    bmf_fault_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .cell_result(cell_res),
        .aux_result(aux_res), .comparator_low_in(cmp_lo), .comparator_high_in(cmp_hi),
        .system_fault_flags(sys_f), .upper_link_port(up_port), .lower_link_port(lo_port),
        .upper_link_stop_q(up_stop), .lower_link_stop_q(lo_stop),
        .fault_category_summary_q(sum_q));
    bmf_link_model i_up (.pclk(pclk), .port(up_port));
    bmf_link_model i_lo (.pclk(pclk), .port(lo_port));

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_word
    task automatic check_bit(input string nm, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask : check_bit
    // Read data and the error flag are taken at the rising edge that sees pready_q high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready_q !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) n_errors++;
        rd = prdata_q;
        err = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, d, x, y);
    endtask : wr
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic        y;
        apb(1'b0, a, 32'h0, x, y);
        check_word(nm, exp, x);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        cell_res = {NUM_CELLS{16'h8000}};
        aux_res = {NUM_AUX{16'h8000}};
        {cmp_lo, cmp_hi, sys_f} = '0;
        idle(10);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd("reset", RA[i], RA[i] inside {12'h184, 12'h190} ? 32'hFFFF0000 : 32'h0);
        end
        apb(1'b0, 12'h1FC, 32'h0, r, e);
        check_bit("unmapped_err", 1'b1, e);
        check_word("unmapped_data", 32'h0, r);
        wr(12'h184, 32'hF0001000);
        @(posedge pclk);
        cell_res[0] <= 16'h0FFF;
        cell_res[1] <= 16'h1000;
        cell_res[14] <= 16'hF000;
        cell_res[15] <= 16'hF001;
        rd("cell_low", 12'h150, 32'h1);
        rd("cell_high", 12'h158, 32'h8000);
        rd("summary", 12'h188, 32'hC000);
        @(posedge pclk);
        cell_res[0] <= 16'h8000;
        rd("cell_low", 12'h150, 32'h1);
        wr(12'h150, 32'hFFFE);
        rd("cell_low", 12'h150, 32'h1);
        wr(12'h150, 32'h1);
        rd("cell_low", 12'h150, 32'h0);
        wr(12'h158, 32'h8000);
        rd("cell_high", 12'h158, 32'h8000);
        @(posedge pclk);
        cell_res[15] <= 16'h8000;
        wr(12'h158, 32'h8000);
        rd("summary", 12'h188, 32'h0);
        wr(12'h190, 32'hF0001000);
        wr(12'h1AC, 32'hF0001000);
        @(posedge pclk);
        aux_res[0] <= 16'h0FFF;
        aux_res[7] <= 16'hF001;
        rd("aux", 12'h160, 32'h0180);
        @(posedge pclk);
        aux_res <= {NUM_AUX{16'h8000}};
        wr(12'h160, 32'hFFFF);
        rd("aux", 12'h160, 32'h0);
        wr(12'h180, 32'h1);
        @(posedge pclk);
        cell_res[3] <= 16'h0001;
        aux_res[0] <= 16'hFFFF;
        rd("cell_low", 12'h150, 32'h8);
        rd("aux", 12'h160, 32'h1);
        @(posedge pclk);
        cell_res[3] <= 16'h8000;
        aux_res[0] <= 16'h8000;
        idle(2);
        rd("cell_low", 12'h150, 32'h0);
        rd("aux", 12'h160, 32'h0);
        @(posedge pclk);
        cmp_lo[3] <= 1'b1;
        cmp_hi[0] <= 1'b1;
        rd("cmp_low", 12'h168, 32'h8);
        rd("cmp_high", 12'h170, 32'h1);
        @(posedge pclk);
        cmp_lo <= '0;
        idle(2);
        rd("cmp_low", 12'h168, 32'h8);
        @(posedge pclk);
        cmp_hi <= '0;
        sys_f[2] <= 1'b1;
        idle(2);
        rd("cmp_low", 12'h168, 32'h8);
        rd("cmp_high", 12'h170, 32'h1);
        @(posedge pclk);
        sys_f <= '0;
        idle(2);
        rd("cmp_low", 12'h168, 32'h0);
        rd("cmp_high", 12'h170, 32'h0);
        wr(12'h180, 32'h0);
        i_up.frame(8, 8'h04, 1'b1);
        idle(3);
        rd("link", 12'h178, 32'h8000);
        @(negedge pclk);
        check_bit("upper_stop", 1'b0, up_stop);
        i_lo.frame(8, 8'h06, 1'b0);
        idle(3);
        @(negedge pclk);
        check_bit("lower_stop", 1'b1, lo_stop);
        rd("link", 12'h178, 32'hD000);
        i_up.frame(4, 8'h09, 1'b0);
        i_lo.frame(1, 8'h00, 1'b1);
        idle(2);
        @(negedge pclk);
        check_bit("lower_stop", 1'b0, lo_stop);
        check_bit("upper_stop", 1'b1, up_stop);
        i_up.frame(1, 8'h00, 1'b1);
        idle(2);
        @(negedge pclk);
        check_bit("upper_stop", 1'b0, up_stop);
        rd("link", 12'h178, 32'hF000);
        rd("summary", 12'h188, 32'h0200);
        wr(12'h178, 32'hF000);
        rd("link", 12'h178, 32'h0);
        final_report();
    end
endmodule : battery_monitor_fault_flags_test
